// ===== verilog/hp_slot_pkg.sv
// constants, field positions and state codes of the hot-plug slot register bank
// assumes a single core clock and one apb slave above this bank
//
// Overview of operation
// - power indicator field reads state, write drives it
// - indicator field reads zero without indicator presence
// - control fields read zero when capability disabled
// - enabled fields start from initial-value register
// - upstream port stores indicator writes but never drives them
// - power bit reads state; zero on, one off
// - interlock control bit always reads zero
// - writing one toggles interlock, zero keeps
// - link active change raises interrupt when enabled
// - button flag set on press, cleared by one
// - fault flag set on fault, cleared by one
// - global enable gates every hot-plug interrupt
// - button enable lets button flag interrupt
// - fault enable lets fault flag interrupt
// - one control write is one command
package hp_slot_pkg;

	// ************************************************************
	// register indices and byte addresses (index times four)
	// ************************************************************
	localparam logic [11:0] CTL_INDEX      = 12'h058;         // slot control index
	localparam logic [11:0] STS_INDEX      = 12'h05a;         // slot status index
	localparam logic [11:0] CTL_ADDR       = 12'h0160;        // slot control byte address
	localparam logic [11:0] STS_ADDR       = 12'h0168;        // slot status byte address
	localparam logic [11:0] CAP_ADDR       = 12'h0200;        // slot capabilities
	localparam logic [11:0] INIT_ADDR      = 12'h0204;        // control initial values
	localparam logic [11:0] MASK_ADDR      = 12'h0208;        // interrupt mask

	// ************************************************************
	// slot control field positions
	// ************************************************************
	localparam int CTL_BUTTON_EN    = 0;                      // button_pressed_en
	localparam int CTL_FAULT_EN     = 1;                      // power_fault_en
	localparam int CTL_IRQ_EN       = 5;                      // hotplug_irq_en
	localparam int CTL_IND_LO       = 8;                      // power_indicator_ctl low bit
	localparam int CTL_POWER        = 10;                     // slot_power_ctl
	localparam int CTL_INTERLOCK    = 11;                     // interlock_toggle
	localparam int CTL_LINK_EN      = 12;                     // link_active_change_en
	localparam logic [15:0] CTL_WRITABLE = 16'h17e3;          // bits 15:13, 11 and 4:2 never stored

	// ************************************************************
	// slot status field positions
	// ************************************************************
	localparam int STS_BUTTON       = 0;                      // button_pressed_flag
	localparam int STS_FAULT        = 1;                      // power_fault_flag
	localparam int STS_CMD_DONE     = 4;                      // command_done_flag
	localparam int STS_LINK         = 8;                      // link active state changed

	// ************************************************************
	// slot capabilities field positions
	// ************************************************************
	localparam int CAP_BUTTON       = 0;                      // attention button present
	localparam int CAP_POWER        = 1;                      // power controller present
	localparam int CAP_INTERLOCK    = 2;                      // interlock present
	localparam int CAP_INDICATOR    = 3;                      // power_indicator_present
	localparam int CAP_UPSTREAM     = 4;                      // port is the upstream port

	// ************************************************************
	// reset values and indicator codes
	// ************************************************************
	localparam logic [4:0]  CAP_RESET      = 5'h0f;          // all slot features, downstream
	localparam logic [15:0] INIT_RESET     = 16'h0723;       // indicator off, power off
	localparam logic [15:0] MASK_RESET     = 16'hffff;       // every status source unmasked
	localparam logic [1:0]  IND_ON         = 2'h1;           // indicator on
	localparam logic [1:0]  IND_BLINK      = 2'h2;           // indicator blink
	localparam logic [1:0]  IND_OFF        = 2'h3;           // indicator off

	// command tracking states
	typedef enum logic [1:0] {
		CMD_IDLE  = 2'b01,                                  // no command outstanding
		CMD_APPLY = 2'b10                                   // pins updated, report next
	} cmd_state_type;

endpackage : hp_slot_pkg

// ===== verilog/pin_sync.sv
// three-stage synchroniser with agreement filter and rising-edge pulse
// assumes inputs come from slot pins, asynchronous to core_clk
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 2                                 // number of pins
) (
	input  wire logic             core_clk,                 // core clock
	input  wire logic             rst_n,                    // synchronous reset, low
	input  wire logic [WIDTH-1:0] pin_in,                   // raw pin levels
	output logic      [WIDTH-1:0] level,                    // filtered level
	output logic      [WIDTH-1:0] rise                      // one-cycle rising pulse
);

	// ************************************************************
	// synchroniser stages
	// ************************************************************
	logic [WIDTH-1:0] stage1;                               // read only by stage2
	logic [WIDTH-1:0] stage2;                               // second stage
	logic [WIDTH-1:0] stage3;                               // third stage
	logic [WIDTH-1:0] next_level;                           // next filtered level
	logic [WIDTH-1:0] next_rise;                            // next edge pulse

	// a change counts only once stage2 and stage3 agree
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level[i];
		end
		next_rise = next_level & ~level;
	end

	// register the stages and the filtered outputs
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			level  <= '0;
			rise   <= '0;
		end else begin
			stage1 <= pin_in;
			stage2 <= stage1;
			stage3 <= stage2;
			level  <= next_level;
			rise   <= next_rise;
		end
	end

endmodule : pin_sync

// ===== verilog/hot_plug_slot_control_status.sv
// slot control and slot status registers of one port, behind an apb slave
// assumes button and fault pins are asynchronous; link_active is on core_clk
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module hot_plug_slot_control_status #(
	parameter logic [4:0]  CAP_INIT  = hp_slot_pkg::CAP_RESET,  // capabilities after reset
	parameter logic [15:0] CTL_INIT  = hp_slot_pkg::INIT_RESET  // initial values after reset
) (
	input  wire logic        core_clk,                      // 100 MHz core clock
	input  wire logic        rst_n,                         // synchronous reset, low
	input  wire logic        psel,                          // apb select
	input  wire logic        penable,                       // apb enable
	input  wire logic        pwrite,                        // apb direction
	input  wire logic [11:0] paddr,                         // apb byte address
	input  wire logic [31:0] pwdata,                        // apb write data
	output logic      [31:0] prdata,                        // apb read data
	output logic             pready,                        // apb ready
	output logic             pslverr,                       // apb error
	input  wire logic        button_pin,                    // attention button, high pressed
	input  wire logic        fault_pin,                     // power fault report, high fault
	input  wire logic        link_active,                   // data link layer active level
	output logic      [1:0]  indicator_drive,               // power indicator state
	output logic             slot_power_off,                // high removes slot power
	output logic             interlock_engaged,             // interlock state
	output logic             hotplug_irq                    // level interrupt
);

	// ************************************************************
	// register state
	// ************************************************************
	logic [4:0]  slot_capabilities;                         // capability enables
	logic [15:0] slot_control_init_value;                   // initial control values
	logic [15:0] irq_mask;                                  // one lets a status bit through
	logic [1:0]  power_indicator_ctl;                       // stored indicator code
	logic        slot_power_ctl;                            // stored power state
	logic        button_pressed_en;                         // button interrupt enable
	logic        power_fault_en;                            // fault interrupt enable
	logic        hotplug_irq_en;                            // global enable
	logic        link_active_change_en;                     // link change enable
	logic        button_pressed_flag;                       // sticky button status
	logic        power_fault_flag;                          // sticky fault status
	logic        command_done_flag;                         // sticky command status
	logic        link_change_flag;                          // sticky link change status
	logic        link_active_prev;                          // last link level
	hp_slot_pkg::cmd_state_type cmd_state;                  // command tracker

	// next values
	logic [4:0]  next_caps;
	logic [15:0] next_init;
	logic [15:0] next_mask;
	logic [1:0]  next_indicator_ctl;
	logic        next_power_ctl;
	logic        next_button_en;
	logic        next_fault_en;
	logic        next_irq_en;
	logic        next_link_en;
	logic        next_button_flag;
	logic        next_fault_flag;
	logic        next_done_flag;
	logic        next_link_flag;
	logic [1:0]  next_indicator_drive;
	logic        next_interlock;
	logic [31:0] next_prdata;
	hp_slot_pkg::cmd_state_type next_cmd_state;

	// ************************************************************
	// bus decode
	// ************************************************************
	logic        setup_phase;                               // first cycle of a transfer
	logic        access_phase;                              // completing cycle
	logic        addr_mapped;                               // address hits a register
	logic        wr_ctl;                                    // control written this edge
	logic        wr_sts;                                    // status written this edge
	logic [15:0] ctl_view;                                  // control as software reads it
	logic [15:0] sts_view;                                  // status as software reads it
	logic [1:0]  pin_rise;                                  // button and fault edges
	logic        link_changed;                              // link level moved

	// true when an access phase writes the given address
	function automatic logic wr_hit(input logic [11:0] target);
		wr_hit = access_phase && pwrite && (paddr == target);
	endfunction : wr_hit

	assign setup_phase  = psel && !penable;
	assign access_phase = psel && penable;
	assign addr_mapped  = (paddr == hp_slot_pkg::CTL_ADDR) || (paddr == hp_slot_pkg::STS_ADDR) ||
		(paddr == hp_slot_pkg::CAP_ADDR) || (paddr == hp_slot_pkg::INIT_ADDR) ||
		(paddr == hp_slot_pkg::MASK_ADDR);
	assign wr_ctl       = wr_hit(hp_slot_pkg::CTL_ADDR);
	assign wr_sts       = wr_hit(hp_slot_pkg::STS_ADDR);
	assign link_changed = link_active ^ link_active_prev;
	// zero-wait slave: read data is captured during setup
	assign pready       = 1'b1;
	assign pslverr      = access_phase && !addr_mapped;

	// slot pins cross into core_clk here
	pin_sync #(
		.WIDTH (2)
	) u_pin_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.pin_in   ({fault_pin, button_pin}),
		.level    (),
		.rise     (pin_rise)
	);

	// ************************************************************
	// read views
	// ************************************************************
	always_comb begin
		ctl_view = 16'h0000;                                // reserved bits stay zero
		// enables of absent features read zero although they hold the init value
		ctl_view[hp_slot_pkg::CTL_BUTTON_EN] = button_pressed_en &&
			slot_capabilities[hp_slot_pkg::CAP_BUTTON];
		ctl_view[hp_slot_pkg::CTL_FAULT_EN]  = power_fault_en &&
			slot_capabilities[hp_slot_pkg::CAP_POWER];
		ctl_view[hp_slot_pkg::CTL_IRQ_EN]    = hotplug_irq_en;
		// indicator readback hidden unless present
		ctl_view[hp_slot_pkg::CTL_IND_LO +: 2] =
			slot_capabilities[hp_slot_pkg::CAP_INDICATOR] ? power_indicator_ctl : 2'h0;
		// power readback hidden without a power controller
		ctl_view[hp_slot_pkg::CTL_POWER]     = slot_power_ctl &&
			slot_capabilities[hp_slot_pkg::CAP_POWER];
		ctl_view[hp_slot_pkg::CTL_INTERLOCK] = 1'b0;
		ctl_view[hp_slot_pkg::CTL_LINK_EN]   = link_active_change_en;
		sts_view = 16'h0000;
		sts_view[hp_slot_pkg::STS_BUTTON]    = button_pressed_flag;
		sts_view[hp_slot_pkg::STS_FAULT]     = power_fault_flag;
		sts_view[hp_slot_pkg::STS_CMD_DONE]  = command_done_flag;
		sts_view[hp_slot_pkg::STS_LINK]      = link_change_flag;
	end

	// ************************************************************
	// next-state logic
	// ************************************************************
	always_comb begin
		next_caps          = slot_capabilities;
		next_init          = slot_control_init_value;
		next_mask          = irq_mask;
		next_indicator_ctl = power_indicator_ctl;
		next_power_ctl     = slot_power_ctl;
		next_button_en     = button_pressed_en;
		next_fault_en      = power_fault_en;
		next_irq_en        = hotplug_irq_en;
		next_link_en       = link_active_change_en;
		next_interlock     = interlock_engaged;
		next_prdata        = prdata;
		next_cmd_state     = cmd_state;
		// own registers
		if (wr_hit(hp_slot_pkg::CAP_ADDR)) begin
			next_caps = pwdata[4:0];
		end
		if (wr_hit(hp_slot_pkg::INIT_ADDR)) begin
			next_init = pwdata[15:0] & hp_slot_pkg::CTL_WRITABLE;
		end
		if (wr_hit(hp_slot_pkg::MASK_ADDR)) begin
			next_mask = pwdata[15:0];
		end
		// one write is one command, whatever fields it touches
		if (wr_ctl) begin
			next_button_en     = pwdata[hp_slot_pkg::CTL_BUTTON_EN];
			next_fault_en      = pwdata[hp_slot_pkg::CTL_FAULT_EN];
			next_irq_en        = pwdata[hp_slot_pkg::CTL_IRQ_EN];
			next_indicator_ctl = pwdata[hp_slot_pkg::CTL_IND_LO +: 2];
			next_power_ctl     = pwdata[hp_slot_pkg::CTL_POWER];
			next_link_en       = pwdata[hp_slot_pkg::CTL_LINK_EN];
			if (pwdata[hp_slot_pkg::CTL_INTERLOCK] &&
				slot_capabilities[hp_slot_pkg::CAP_INTERLOCK]) begin
				next_interlock = !interlock_engaged;
			end
			next_cmd_state = hp_slot_pkg::CMD_APPLY;
		end else begin
			// pins followed the write at the same edge, so the command is done
			next_cmd_state = hp_slot_pkg::CMD_IDLE;
		end
		// absent features read zero and wait at their initial value
		if (!slot_capabilities[hp_slot_pkg::CAP_INDICATOR]) begin
			next_indicator_ctl = slot_control_init_value[hp_slot_pkg::CTL_IND_LO +: 2];
		end
		if (!slot_capabilities[hp_slot_pkg::CAP_POWER]) begin
			next_power_ctl = slot_control_init_value[hp_slot_pkg::CTL_POWER];
			next_fault_en  = slot_control_init_value[hp_slot_pkg::CTL_FAULT_EN];
		end
		if (!slot_capabilities[hp_slot_pkg::CAP_BUTTON]) begin
			next_button_en = slot_control_init_value[hp_slot_pkg::CTL_BUTTON_EN];
		end
		// upstream port never moves the indicator
		next_indicator_drive = slot_capabilities[hp_slot_pkg::CAP_UPSTREAM] ?
			indicator_drive : next_indicator_ctl;
		// sticky flags: a new event beats a clearing write
		next_button_flag = (button_pressed_flag &&
			!(wr_sts && pwdata[hp_slot_pkg::STS_BUTTON])) || pin_rise[0];
		next_fault_flag  = (power_fault_flag &&
			!(wr_sts && pwdata[hp_slot_pkg::STS_FAULT])) || pin_rise[1];
		next_done_flag   = (command_done_flag &&
			!(wr_sts && pwdata[hp_slot_pkg::STS_CMD_DONE])) ||
			(cmd_state == hp_slot_pkg::CMD_APPLY);
		next_link_flag   = (link_change_flag &&
			!(wr_sts && pwdata[hp_slot_pkg::STS_LINK])) || link_changed;
		// read data is loaded in setup so it comes from a flop in access
		if (setup_phase) begin
			next_prdata = 32'h0000_0000;
			case (paddr)
				hp_slot_pkg::CTL_ADDR:  next_prdata = {16'h0000, ctl_view};
				hp_slot_pkg::STS_ADDR:  next_prdata = {16'h0000, sts_view};
				hp_slot_pkg::CAP_ADDR:  next_prdata = {27'h000_0000, slot_capabilities};
				hp_slot_pkg::INIT_ADDR: next_prdata = {16'h0000, slot_control_init_value};
				hp_slot_pkg::MASK_ADDR: next_prdata = {16'h0000, irq_mask};
				default:                next_prdata = 32'h0000_0000;
			endcase
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			slot_capabilities       <= CAP_INIT;
			slot_control_init_value <= CTL_INIT;
			irq_mask                <= hp_slot_pkg::MASK_RESET;
			power_indicator_ctl     <= CTL_INIT[9:8];
			slot_power_ctl          <= CTL_INIT[10];
			button_pressed_en       <= CTL_INIT[0];
			power_fault_en          <= CTL_INIT[1];
			hotplug_irq_en          <= CTL_INIT[5];
			link_active_change_en   <= CTL_INIT[12];
			button_pressed_flag     <= 1'b0;
			power_fault_flag        <= 1'b0;
			command_done_flag       <= 1'b0;
			link_change_flag        <= 1'b0;
			link_active_prev        <= 1'b0;
			indicator_drive         <= hp_slot_pkg::IND_OFF;
			interlock_engaged       <= 1'b0;
			prdata                  <= 32'h0000_0000;
			cmd_state               <= hp_slot_pkg::CMD_IDLE;
		end else begin
			slot_capabilities       <= next_caps;
			slot_control_init_value <= next_init;
			irq_mask                <= next_mask;
			power_indicator_ctl     <= next_indicator_ctl;
			slot_power_ctl          <= next_power_ctl;
			button_pressed_en       <= next_button_en;
			power_fault_en          <= next_fault_en;
			hotplug_irq_en          <= next_irq_en;
			link_active_change_en   <= next_link_en;
			button_pressed_flag     <= next_button_flag;
			power_fault_flag        <= next_fault_flag;
			command_done_flag       <= next_done_flag;
			link_change_flag        <= next_link_flag;
			link_active_prev        <= link_active;
			indicator_drive         <= next_indicator_drive;
			interlock_engaged       <= next_interlock;
			prdata                  <= next_prdata;
			cmd_state               <= next_cmd_state;
		end
	end

	// ************************************************************
	// outputs and interrupt
	// ************************************************************
	// without a power controller the slot stays powered (field reads zero)
	assign slot_power_off = slot_capabilities[hp_slot_pkg::CAP_POWER] && slot_power_ctl;

	// per-source enable, then mask, then the global enable
	assign hotplug_irq = hotplug_irq_en && |(irq_mask & sts_view &
		{7'h00, link_active_change_en, 6'h00, power_fault_en, button_pressed_en});

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	chk_indicator_hidden: assert property (
		!slot_capabilities[hp_slot_pkg::CAP_INDICATOR] |-> ctl_view[9:8] == 2'h0)
		else $error("indicator field visible without indicator");
	chk_interlock_reads: assert property (
		setup_phase && !pwrite && paddr == hp_slot_pkg::CTL_ADDR |=> prdata[11] == 1'b0)
		else $error("interlock bit read as one");
	chk_interlock_toggle: assert property (
		wr_ctl && pwdata[11] && slot_capabilities[hp_slot_pkg::CAP_INTERLOCK]
		|=> interlock_engaged != $past(interlock_engaged))
		else $error("interlock did not toggle");
	chk_interlock_hold: assert property (
		wr_ctl && !pwdata[11] |=> $stable(interlock_engaged))
		else $error("interlock moved on zero write");
	chk_power_drive: assert property (
		wr_ctl && slot_capabilities[hp_slot_pkg::CAP_POWER] && !next_caps[1] == 1'b0
		|=> slot_power_off == $past(pwdata[10]))
		else $error("slot power does not follow write");
	chk_upstream_indicator: assert property (
		slot_capabilities[hp_slot_pkg::CAP_UPSTREAM] |=> $stable(indicator_drive))
		else $error("upstream indicator changed");
	chk_button_sticky: assert property (
		button_pressed_flag && !(wr_sts && pwdata[0]) |=> button_pressed_flag)
		else $error("button flag lost without clear");
	chk_fault_event_wins: assert property (
		pin_rise[1] && wr_sts && pwdata[1] |=> power_fault_flag)
		else $error("clear beat fault event");
	chk_irq_global: assert property (
		!hotplug_irq_en |-> !hotplug_irq)
		else $error("interrupt without global enable");
	chk_link_irq: assert property (
		link_changed && link_active_change_en && hotplug_irq_en && irq_mask[8]
		&& !(wr_sts || wr_ctl) |=> hotplug_irq)
		else $error("link change gave no interrupt");
	chk_cmd_done: assert property (
		wr_ctl |=> ##1 command_done_flag)
		else $error("command completion not reported");

	cov_button_irq: cover property (pin_rise[0] && button_pressed_en ##2 hotplug_irq);
	cov_clear_flag: cover property (power_fault_flag ##1 wr_sts && pwdata[1] ##1 !power_fault_flag);
	cov_toggle:     cover property (wr_ctl && pwdata[11] ##1 interlock_engaged);

endmodule : hot_plug_slot_control_status

// ===== verif/slot_model.sv
// slot side stand-in: attention button and power fault reporter
// assumes press and trip are one-cycle requests from the bench on core_clk
`timescale 1ns/1ps
module slot_model (
	input  wire logic core_clk,     // core clock
	input  wire logic rst_n,        // synchronous reset, low
	input  wire logic press,        // request a button press
	input  wire logic trip,         // request a power fault report
	output logic      button_pin,   // high while pressed
	output logic      fault_pin     // high while a fault is reported
);
	logic [3:0] bcnt, fcnt;         // hold counters, long enough to pass the pin filter
	// each request holds its pin for eight cycles, then lets it fall back to idle low
	always_ff @(posedge core_clk) begin
		bcnt <= !rst_n ? 4'h0 : press ? 4'h8 : bcnt - 4'(bcnt != 4'h0);
		fcnt <= !rst_n ? 4'h0 : trip ? 4'h8 : fcnt - 4'(fcnt != 4'h0);
	end
	assign button_pin = bcnt != 4'h0;
	assign fault_pin  = fcnt != 4'h0;
endmodule : slot_model

// ===== verif/testbench.sv
// self-checking bench for the hot-plug slot control and status bank
// assumes default capabilities and init values; slot model drives the pins
`timescale 1ns/1ps
module testbench;
	typedef struct packed {logic [11:0] a; logic [15:0] w, r; logic [3:0] pin;} row_type;
	localparam logic [11:0] ctl = hp_slot_pkg::CTL_ADDR;
	localparam logic [11:0] sts = hp_slot_pkg::STS_ADDR;
	localparam logic [11:0] cap = hp_slot_pkg::CAP_ADDR;
	localparam logic [11:0] msk = hp_slot_pkg::MASK_ADDR;
	logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic press = 1'b0, trip = 1'b0, link_active = 1'b0, pready, pslverr, button_pin, fault_pin;
	logic slot_power_off, interlock_engaged, hotplug_irq, slverr_seen;
	logic [1:0]  indicator_drive;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, q;
	wire  [3:0]  pins = {indicator_drive, slot_power_off, interlock_engaged};
	int failures = 0, checks_done = 0;
	// rows carry state forward: pin nibble is indicator, power off, interlock
	row_type rows [14] = '{'{ctl, 16'h0123, 16'h0123, 4'h4}, '{ctl, 16'hf9a3, 16'h1123, 4'h5},
		'{ctl, 16'h0623, 16'h0623, 4'hb}, '{ctl, 16'h0b23, 16'h0323, 4'hc},
		'{cap, 16'h001f, 16'h001f, 4'hc}, '{ctl, 16'h0123, 16'h0123, 4'hc},
		'{ctl, 16'h0323, 16'h0323, 4'hc}, '{cap, 16'h0009, 16'h0009, 4'hc},
		'{ctl, 16'h0f01, 16'h0301, 4'hc}, '{cap, 16'h000f, 16'h000f, 4'he},
		'{cap, 16'h0007, 16'h0007, 4'he}, '{ctl, 16'h0123, 16'h0023, 4'hc},
		'{cap, 16'h000f, 16'h000f, 4'hc}, '{12'h300, 16'h1234, 16'h0000, 4'hc}};
	always #5 core_clk = ~core_clk;
	slot_model slot_u (.core_clk, .rst_n, .press, .trip, .button_pin, .fault_pin);
	hot_plug_slot_control_status dut_u (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .button_pin, .fault_pin, .link_active,
		.indicator_drive, .slot_power_off, .interlock_engaged, .hotplug_irq);
	task complete_run;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// one apb transfer; request held until pready is seen high, bounded wait
	task apb(input logic w, input logic [11:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 16'h0000, d};
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		q = prdata;
		slverr_seen = pslverr;
		{psel, penable} <= 2'b00;
		if (pready !== 1'b1) begin failures++; complete_run(); end
		else @(negedge core_clk);
	endtask : apb
	// event kinds: 0 button press, 1 power fault, 2 link active change
	task ev(input int k, input logic [15:0] b);
		int n;
		apb(1'b1, sts, 16'hffff);
		@(posedge core_clk);
		{press, trip, link_active} <= {k == 0, k == 1, link_active ^ (k == 2)};
		@(posedge core_clk);
		{press, trip} <= 2'b00;
		for (n = 0; n < 20 && hotplug_irq !== 1'b1; n++) @(negedge core_clk);
		if (hotplug_irq !== 1'b1) begin failures++; complete_run(); end
		apb(1'b0, sts, 16'h0000);
		chk(q, {16'h0000, b});
		apb(1'b1, msk, 16'h0000);
		chk({31'h0, hotplug_irq}, 32'h0);
		apb(1'b1, msk, 16'hffff);
		apb(1'b1, sts, 16'h0000);
		chk({31'h0, hotplug_irq}, 32'h1);
		apb(1'b1, sts, b);
		chk({31'h0, hotplug_irq}, 32'h0);
	endtask : ev
	initial begin
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		apb(1'b0, ctl, 16'h0000);
		chk(q, 32'h0000_0723);
		chk({28'h0, pins}, 32'he);
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, rows[i].w);
			apb(1'b0, rows[i].a, 16'h0000);
			chk(q, {16'h0000, rows[i].r});
			chk({28'h0, pins}, {28'h0, rows[i].pin});
			chk({31'h0, slverr_seen}, {31'h0, rows[i].a == 12'h300});
		end
		apb(1'b1, sts, 16'hffff);
		apb(1'b1, ctl, 16'h1323);
		@(negedge core_clk);
		apb(1'b0, sts, 16'h0000);
		chk(q, 32'h0000_0010);
		ev(0, 16'h0001);
		ev(1, 16'h0002);
		ev(2, 16'h0100);
		complete_run();
	end
endmodule : testbench
